// ==== inc/adc_pkg.sv ====
// constants and carrier types for the async x16 dram controller
// assumes a 50 MHz mclk and a 1M x16 dram with 10 address pins
package adc_pkg;
  localparam int ADC_CLK_MHZ = 50;
  localparam int ADC_WAKE_US = 200;
  localparam int ADC_WAKE_CYC = ADC_WAKE_US * ADC_CLK_MHZ;
  localparam int ADC_WAKE_REFS = 8;
  localparam int ADC_REF_ROWS = 1024;
  localparam int ADC_REF_MS = 16;
  // longest spacing per row, rounded down
  localparam int ADC_REF_CYC = (ADC_REF_MS * 1000 * ADC_CLK_MHZ) / ADC_REF_ROWS;
  // phase lengths in ns, least times rounded up to 20 ns cycles
  localparam int ADC_CLK_NS = 1000 / ADC_CLK_MHZ;
  localparam int ADC_TRP_NS = 30;
  localparam int ADC_TRAS_NS = 50;
  localparam int ADC_TRCD_NS = 14;
  localparam int ADC_TCAS_NS = 30;
  localparam int ADC_TRWD_NS = 65;
  localparam int ADC_TRP_CYC = (ADC_TRP_NS + ADC_CLK_NS - 1) / ADC_CLK_NS;
  localparam int ADC_TRAS_CYC = (ADC_TRAS_NS + ADC_CLK_NS - 1) / ADC_CLK_NS;
  localparam int ADC_TRCD_CYC = (ADC_TRCD_NS + ADC_CLK_NS - 1) / ADC_CLK_NS;
  localparam int ADC_TCAS_CYC = (ADC_TCAS_NS + ADC_CLK_NS - 1) / ADC_CLK_NS;
  localparam int ADC_TRWD_CYC = (ADC_TRWD_NS + ADC_CLK_NS - 1) / ADC_CLK_NS;
  localparam int ADC_AW = 10;
  localparam int ADC_DW = 16;
  typedef enum logic [1:0] {ADC_OP_READ, ADC_OP_WRITE, ADC_OP_RMW} adc_op_t;
  typedef struct packed {
    adc_op_t op;
    logic [1:0] byte_en;
    logic [ADC_AW-1:0] row;
    logic [ADC_AW-1:0] col;
    logic [ADC_DW-1:0] wdata;
  } adc_req_t;
  typedef struct packed {
    logic ras_n;
    logic lower_byte_col_strobe_n;
    logic upper_byte_col_strobe_n;
    logic we_n;
    logic oe_n;
    logic [ADC_AW-1:0] addr;
  } adc_pins_t;
endpackage

// ==== rtl/adc_timer.sv ====
// down-counter used for phase waits
// assumes a load pulse and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module adc_timer #(
  parameter int W = 14
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  always_comb
  begin
    cnt_next = cnt_reg;
    if (load)
      cnt_next = value;
    else if (cnt_reg != '0)
      cnt_next = cnt_reg - 1'b1;
  end
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
  // no path from load to done: the caller's load depends on done
  assign done = (cnt_reg == '0);
endmodule
`default_nettype wire

// ==== rtl/adc_ctrl.sv ====
// host-side controller for an async x16 extended-output dram
// assumes dram inputs see the pins one mclk after they change
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl #(
  parameter int WAKE_CYC = adc_pkg::ADC_WAKE_CYC,
  parameter int REF_CYC = adc_pkg::ADC_REF_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire adc_pkg::adc_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [adc_pkg::ADC_DW-1:0] rdata,
  output logic rdata_valid,
  output logic init_done,
  output adc_pkg::adc_pins_t pins,
  input wire logic [adc_pkg::ADC_DW-1:0] dq_in,
  output logic [adc_pkg::ADC_DW-1:0] dq_out,
  output logic [1:0] dq_oe
);
  import adc_pkg::*;
  // timer and interval counters are 14 bits wide
  if (WAKE_CYC < 1 || WAKE_CYC > 16383 || REF_CYC < 16 || REF_CYC > 16383)
  begin : g_bad_counts
    $error("adc_ctrl: counts out of range");
  end

  typedef enum logic [3:0] {
    S_WAKE, S_REF_CAS, S_REF_RAS, S_REF_PRE, S_IDLE, S_ROW, S_COL, S_RDWAIT,
    S_WRITE, S_END, S_PRE
  } adc_state_t;

  adc_state_t state_reg, state_next;
  adc_pins_t pins_reg, pins_next;
  adc_req_t cur_reg, cur_next;
  logic [3:0] refn_reg, refn_next;
  logic wake_reg, wake_next;
  logic [13:0] ival_reg, ival_next;
  logic ref_due_reg, ref_due_next;
  logic [ADC_DW-1:0] dqo_reg, dqo_next, rd_reg, rd_next;
  logic [1:0] oe_reg, oe_next;
  logic rv_reg, rv_next, rdy_reg, rdy_next, init_reg, init_next;
  logic t_load, t_done;
  logic [13:0] t_val;

  adc_timer #(.W(14)) u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .load(t_load),
    .value(t_val),
    .done(t_done)
  );

  always_comb
  begin
    state_next = state_reg;
    pins_next = pins_reg;
    cur_next = cur_reg;
    refn_next = refn_reg;
    wake_next = wake_reg;
    dqo_next = dqo_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    rv_next = 1'b0;
    rdy_next = 1'b0;
    init_next = init_reg;
    t_load = 1'b0;
    t_val = '0;
    // refresh pacing: one row per interval
    ival_next = ival_reg - 14'h1;
    ref_due_next = ref_due_reg;
    if (ival_reg == 14'h0)
    begin
      ival_next = 14'(REF_CYC - 1);
      if (ref_due_reg && state_reg != S_WAKE)
        wake_next = 1'b1;
      ref_due_next = 1'b1;
    end
    case (state_reg)
      S_WAKE:
      begin
        if (refn_reg == 4'h0)
        begin
          // all-ones marks the pause as loaded
          refn_next = 4'hf;
          t_load = 1'b1;
          t_val = 14'(WAKE_CYC);
        end
        else if (t_done)
        begin
          refn_next = 4'(ADC_WAKE_REFS);
          wake_next = 1'b1;
          state_next = S_REF_CAS;
        end
      end
      S_REF_CAS:
      begin
        pins_next.lower_byte_col_strobe_n = 1'b0;
        pins_next.upper_byte_col_strobe_n = 1'b0;
        pins_next.we_n = 1'b1;
        state_next = S_REF_RAS;
      end
      S_REF_RAS:
      begin
        pins_next.ras_n = 1'b0;
        t_load = 1'b1;
        t_val = 14'(ADC_TRAS_CYC);
        state_next = S_REF_PRE;
      end
      S_REF_PRE:
      begin
        if (t_done)
        begin
          pins_next = '{ras_n: 1'b1, lower_byte_col_strobe_n: 1'b1,
                        upper_byte_col_strobe_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                        addr: '0};
          t_load = 1'b1;
          t_val = 14'(ADC_TRP_CYC);
          if (refn_reg > 4'h1)
          begin
            refn_next = refn_reg - 4'h1;
            state_next = S_PRE;
          end
          else
          begin
            refn_next = 4'h0;
            wake_next = 1'b0;
            // a tick in this same cycle wins over the clear
            ref_due_next = (ival_reg == 14'h0);
            state_next = S_PRE;
          end
        end
      end
      S_PRE:
      begin
        if (t_done)
        begin
          if (refn_reg != 4'h0)
            state_next = S_REF_CAS;
          else
          begin
            init_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_IDLE:
      begin
        if (wake_reg)
        begin
          refn_next = 4'(ADC_WAKE_REFS);
          state_next = S_REF_CAS;
        end
        else if (ref_due_reg)
        begin
          refn_next = 4'h1;
          state_next = S_REF_CAS;
        end
        else if (req_valid && !rdy_reg)
        begin
          rdy_next = 1'b1;
          cur_next = req;
          pins_next.addr = req.row;
          state_next = S_ROW;
        end
      end
      S_ROW:
      begin
        pins_next.ras_n = 1'b0;
        pins_next.we_n = (cur_reg.op == ADC_OP_WRITE) ? 1'b0 : 1'b1;
        pins_next.oe_n = (cur_reg.op == ADC_OP_WRITE) ? 1'b1 : 1'b0;
        if (cur_reg.op == ADC_OP_WRITE)
        begin
          dqo_next = cur_reg.wdata;
          oe_next = cur_reg.byte_en;
        end
        t_load = 1'b1;
        t_val = 14'(ADC_TRCD_CYC);
        state_next = S_COL;
      end
      S_COL:
      begin
        pins_next.addr = cur_reg.col;
        if (t_done)
        begin
          pins_next.lower_byte_col_strobe_n = ~cur_reg.byte_en[0];
          pins_next.upper_byte_col_strobe_n = ~cur_reg.byte_en[1];
          t_load = 1'b1;
          t_val = 14'((cur_reg.op == ADC_OP_RMW) ? ADC_TRWD_CYC : ADC_TCAS_CYC);
          state_next = S_RDWAIT;
        end
      end
      S_RDWAIT:
      begin
        if (t_done)
        begin
          if (cur_reg.op == ADC_OP_WRITE)
            state_next = S_END;
          else
          begin
            rd_next = dq_in;
            rv_next = 1'b1;
            if (cur_reg.op == ADC_OP_RMW)
            begin
              pins_next.oe_n = 1'b1;
              state_next = S_WRITE;
            end
            else
              state_next = S_END;
          end
        end
      end
      S_WRITE:
      begin
        pins_next.we_n = 1'b0;
        dqo_next = cur_reg.wdata;
        oe_next = cur_reg.byte_en;
        t_load = 1'b1;
        t_val = 14'(ADC_TCAS_CYC);
        state_next = S_END;
      end
      S_END:
      begin
        if (t_done)
        begin
          pins_next = '{ras_n: 1'b1, lower_byte_col_strobe_n: 1'b1,
                        upper_byte_col_strobe_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                        addr: '0};
          oe_next = 2'b00;
          t_load = 1'b1;
          t_val = 14'(ADC_TRP_CYC);
          state_next = S_PRE;
        end
      end
      default:
        state_next = S_WAKE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_reg <= S_WAKE;
      pins_reg <= '{ras_n: 1'b1, lower_byte_col_strobe_n: 1'b1,
                    upper_byte_col_strobe_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
      cur_reg <= '0;
      refn_reg <= 4'h0;
      wake_reg <= 1'b1;
      ival_reg <= 14'(REF_CYC - 1);
      ref_due_reg <= 1'b0;
      dqo_reg <= '0;
      oe_reg <= 2'b00;
      rd_reg <= '0;
      rv_reg <= 1'b0;
      rdy_reg <= 1'b0;
      init_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      cur_reg <= cur_next;
      refn_reg <= refn_next;
      wake_reg <= wake_next;
      ival_reg <= ival_next;
      ref_due_reg <= ref_due_next;
      dqo_reg <= dqo_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
      rv_reg <= rv_next;
      rdy_reg <= rdy_next;
      init_reg <= init_next;
    end
  end

  assign pins = pins_reg;
  assign dq_out = dqo_reg;
  assign dq_oe = oe_reg;
  assign rdata = rd_reg;
  assign rdata_valid = rv_reg;
  assign req_ready = rdy_reg;
  assign init_done = init_reg;
endmodule
`default_nettype wire

// ==== dv/adc_ctrl_properties.sv ====
// pin-order and wake-up checks on adc_ctrl
// bound into adc_ctrl below; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_properties #(
  parameter int WAKE_CYC = 20,
  parameter int REF_CYC = 100
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_ready,
  input wire logic init_done,
  input wire adc_pkg::adc_pins_t pins,
  input wire logic [1:0] dq_oe
);
  import adc_pkg::*;
  logic rn, ln, column_first_refresh, rp_reg, rp_next;
  logic [3:0] nref_reg, nref_next;
  logic [15:0] up_reg, up_next;
  assign rn = pins.ras_n;
  assign ln = pins.lower_byte_col_strobe_n;
  assign column_first_refresh = rp_reg && !rn && !ln;
  // counters saturate so long runs never wrap
  always_comb
  begin
    rp_next = nrst ? rn : 1'b1;
    nref_next = !nrst ? 4'h0 : nref_reg + {3'h0, column_first_refresh && nref_reg != 4'hf};
    up_next = !nrst ? 16'h0 : up_reg + {15'h0, up_reg != 16'hffff};
  end
  always_ff @(posedge mclk)
  begin
    rp_reg <= rp_next;
    nref_reg <= nref_next;
    up_reg <= up_next;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_RESET_QUIET: assert property (disable iff (1'b0) !nrst |=> rn && ln && dq_oe == 2'h0)
    else $error("strobes busy after reset");
  AST_WAKE_WAIT: assert property ($fell(rn) |-> up_reg >= 16'(WAKE_CYC))
    else $error("row strobe before power-up wait");
  AST_WAKE_REFS: assert property ($rose(init_done) |-> nref_reg >= 4'h8)
    else $error("ready after too few refreshes");
  AST_READY_AFTER_INIT: assert property (req_ready |-> init_done)
    else $error("request taken before wake-up");
  AST_RAS_WIDTH: assert property ($fell(rn) |-> !rn [*3])
    else $error("row strobe pulse short");
  AST_PRECHARGE: assert property ($rose(rn) |-> rn [*2])
    else $error("row precharge short");
  AST_ROW_FIRST: assert property ($fell(ln) && !rn |-> !$past(rn))
    else $error("column fell with row");
  AST_REFRESH_WE: assert property (column_first_refresh |-> pins.we_n)
    else $error("write strobe low in refresh");
  AST_DRIVE_GATE: assert property (dq_oe != 2'h0 |-> pins.oe_n)
    else $error("data driven with gate low");
  cover property ($rose(init_done));
  cover property (column_first_refresh);
  cover property ($fell(pins.we_n));
endmodule
bind adc_ctrl adc_ctrl_properties #(.WAKE_CYC(WAKE_CYC), .REF_CYC(REF_CYC))
  u_adc_ctrl_properties (.mclk(mclk), .nrst(nrst), .req_ready(req_ready),
  .init_done(init_done), .pins(pins), .dq_oe(dq_oe));
`default_nettype wire

// ==== dv/adc_dram_model.sv ====
// behavioural x16 extended-output dram facing adc_ctrl
// assumes pins move only on mclk edges; no ac checks
`timescale 1ns/10ps
`default_nettype none
module adc_dram_model (
  input wire adc_pkg::adc_pins_t pins,
  input wire logic [adc_pkg::ADC_DW-1:0] host_d,
  input wire logic [1:0] host_oe,
  output logic [adc_pkg::ADC_DW-1:0] dq
);
  import adc_pkg::*;
  logic [ADC_DW-1:0] mem [int];
  logic [ADC_DW-1:0] rd = '0;
  logic [ADC_AW-1:0] row = '0;
  logic [ADC_AW-1:0] col = '0;
  logic ew = 1'b0;
  logic l, u, cas;
  logic [1:0] drv;
  int refs = 0;
  assign l = pins.lower_byte_col_strobe_n;
  assign u = pins.upper_byte_col_strobe_n;
  assign cas = !(l && u);
  task automatic wr();
    logic [ADC_DW-1:0] v;
    v = rd;
    if (!l)
      v[7:0] = host_d[7:0];
    if (!u)
      v[15:8] = host_d[15:8];
    mem[{row, col}] = v;
    rd = v;
  endtask
  always @(negedge pins.ras_n)
  begin
    #1;
    if (cas)
      refs++;
    else
      row = pins.addr;
  end
  always @(posedge cas)
  begin
    #1;
    if (!pins.ras_n)
    begin
      col = pins.addr;
      rd = mem.exists({row, col}) ? mem[{row, col}] : '0;
      ew = !pins.we_n;
      if (ew)
        wr();
    end
  end
  always @(negedge cas)
    ew = 1'b0;
  always @(negedge pins.we_n)
  begin
    #1;
    if (cas && !pins.ras_n)
      wr();
  end
  assign drv = {!u, !l} & {2{!pins.oe_n && !ew}};
  // a released lane shows the inverse, never a stale match
  assign dq[7:0] = host_oe[0] ? host_d[7:0] : (drv[0] ? rd[7:0] : ~rd[7:0]);
  assign dq[15:8] = host_oe[1] ? host_d[15:8] : (drv[1] ? rd[15:8] : ~rd[15:8]);
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for adc_ctrl and a dram model
// assumes package, design, checker and model compile first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import adc_pkg::*;
  typedef struct packed {
    adc_req_t r;
    logic [ADC_DW-1:0] exp;
  } adc_row_t;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  adc_req_t req = '0;
  logic req_ready, rdata_valid, init_done;
  logic [ADC_DW-1:0] rdata, dq_in, dq_out, got;
  logic [1:0] dq_oe;
  adc_pins_t pins;
  int fails = 0;
  int num_checks = 0;
  int n0;
  adc_row_t rows [9] = '{
    '{'{ADC_OP_WRITE, 2'h3, 10'h3, 10'h5, 16'h1234}, 16'h0},
    '{'{ADC_OP_READ, 2'h3, 10'h3, 10'h5, 16'h0}, 16'h1234},
    '{'{ADC_OP_WRITE, 2'h1, 10'h3, 10'h5, 16'habcd}, 16'h0},
    '{'{ADC_OP_READ, 2'h3, 10'h3, 10'h5, 16'h0}, 16'h12cd},
    '{'{ADC_OP_WRITE, 2'h2, 10'h3ff, 10'h3ff, 16'h5a5a}, 16'h0},
    '{'{ADC_OP_READ, 2'h3, 10'h3ff, 10'h3ff, 16'h0}, 16'h5a00},
    '{'{ADC_OP_RMW, 2'h3, 10'h3, 10'h5, 16'h0f0f}, 16'h12cd},
    '{'{ADC_OP_READ, 2'h1, 10'h3, 10'h5, 16'h0}, 16'h000f},
    '{'{ADC_OP_READ, 2'h2, 10'h3, 10'h5, 16'h0}, 16'h0f00}};
  adc_ctrl #(.WAKE_CYC(20), .REF_CYC(100)) u_adc_ctrl (.mclk(mclk), .nrst(nrst),
    .req(req), .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
    .rdata_valid(rdata_valid), .init_done(init_done), .pins(pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  adc_dram_model u_adc_dram_model (.pins(pins), .host_d(dq_out), .host_oe(dq_oe),
    .dq(dq_in));
  always #10 mclk = ~mclk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // an edge passes before each request, so valid never drops and rises at once
  // outputs sampled 1 ns after the edge, once settled; masks unselected lanes
  task automatic access(input adc_req_t r, output logic [ADC_DW-1:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    req = r;
    req_valid = 1'b1;
    do
    begin
      @(posedge mclk);
      #1;
    end
    while (req_ready !== 1'b1 && ++n < 400);
    req_valid = 1'b0;
    chk("req_ready", 16'h1, 16'(req_ready));
    chk("init_done", 16'h1, 16'(init_done));
    if (r.op != ADC_OP_WRITE)
    begin
      do
      begin
        @(posedge mclk);
        #1;
      end
      while (rdata_valid !== 1'b1 && ++n < 400);
      chk("rdata_valid", 16'h1, 16'(rdata_valid));
    end
    d = rdata & {{8{r.byte_en[1]}}, {8{r.byte_en[0]}}};
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    #1 chk("reset_strobes", 16'h1f, 16'(pins[14:10]));
    chk("reset_drive", 16'h0, 16'({dq_oe, init_done}));
    nrst = 1'b1;
    foreach (rows[i])
    begin
      access(rows[i].r, got);
      if (rows[i].r.op != ADC_OP_WRITE)
        chk("rdata", rows[i].exp, got);
    end
    n0 = u_adc_dram_model.refs;
    repeat (350) @(posedge mclk);
    #1 chk("refresh_count", 16'h1, 16'(u_adc_dram_model.refs - n0 >= 3));
    req = rows[1].r;
    req_valid = 1'b1;
    repeat (3) @(posedge mclk);
    #1 nrst = 1'b0;
    req_valid = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("abort_strobes", 16'h1f, 16'(pins[14:10]));
    nrst = 1'b1;
    access(rows[1].r, got);
    chk("rdata_after_reset", 16'h0f0f, got);
    finish_test();
  end
  initial
  begin
    #200000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
